// File: include/xoc_pkg.sv
// Purpose: Shared constants and types for the crystal oscillator control block.
// Assumes: One 8-bit control register on a plain strobe port.
// Notes:   Bit positions, masks, reset value and the startup count live here.

package xoc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register map.
   localparam int unsigned REG_ADDR_W      = 4;
   localparam logic [3:0]  OSC_CTRL_OFFSET = 4'h0;
   localparam logic [7:0]  CTRL_RESET      = 8'h00;
   // Bits that software may write; reserved bits and the status flag excluded.
   localparam logic [7:0]  CTRL_WRITE_MASK = 8'hB6;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions of the control register.
   localparam int unsigned BIT_ENABLE      = 7;
   localparam int unsigned BIT_RSVD_HI     = 6;
   localparam int unsigned BIT_STOP_KEEP   = 5;
   localparam int unsigned BIT_OUT_SEL     = 4;
   localparam int unsigned BIT_RSVD_LO     = 3;
   localparam int unsigned BIT_RANGE       = 2;
   localparam int unsigned BIT_HIGH_GAIN   = 1;
   localparam int unsigned BIT_INIT_DONE   = 0;

   ////////////////////////////////////////////////////////////////////////////
   // Timing.
   localparam int unsigned CLOCK_MHZ       = 100;
   localparam int unsigned STARTUP_CYCLES  = 4096;

   ////////////////////////////////////////////////////////////////////////////
   // Oscillator states, one-hot.
   typedef enum logic [3:0] {
      XOC_ST_OFF     = 4'h1,
      XOC_ST_STARTUP = 4'h2,
      XOC_ST_STABLE  = 4'h4,
      XOC_ST_EXT     = 4'h8
   } xoc_state_type;

endpackage

// File: design/xoc_startup_counter.sv
// Purpose: Counts rising edges of the buffered crystal signal during startup.
// Assumes: The edge pulse is one clock wide and synchronous to clock.
// Notes:   The count saturates at the limit so done holds until cleared.

`timescale 1ns/1ps

module xoc_startup_counter #(
   parameter int unsigned LIMIT = xoc_pkg::STARTUP_CYCLES,
   parameter int unsigned CNT_W = $clog2(LIMIT + 1)
) (
   input  wire logic clock,      // System clock.
   input  wire logic nrst,       // Synchronous reset, active low.
   input  wire logic clear,      // Restart the count from zero.
   input  wire logic edge_pulse, // One rising crystal edge seen.
   output logic      done        // Limit of edges reached.
);

   localparam logic [CNT_W-1:0] LIMIT_C = CNT_W'(LIMIT);

   logic [CNT_W-1:0] count_r;

   ////////////////////////////////////////////////////////////////////////////
   // Edge counter; clear wins so each new enable repeats the full count.
   always_ff @(posedge clock) begin
      if (!nrst || clear) begin
         count_r <= '0; // [R17]
      end else if (edge_pulse && (count_r != LIMIT_C)) begin
         count_r <= count_r + CNT_W'(1); // [R12]
      end
   end

   // Done as soon as the limit of edges has been observed.
   assign done = (count_r == LIMIT_C); // [R13]

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   a_count_saturates: assert property ( // [R13]
      @(posedge clock) disable iff (!nrst)
      (done && !clear) |=> done)
      else $error("startup count left its limit without a clear");

   a_clear_zeroes: assert property ( // [R17]
      @(posedge clock) disable iff (!nrst)
      clear |=> (count_r == '0))
      else $error("startup count not zero after clear");

endmodule

// File: design/xoc_top.sv
// Purpose: Digital control of a crystal oscillator: register, enable, states.
// Assumes: Crystal and external pin signals arrive synchronous to clock.
// Notes:   Output clocks are sampled copies; analog parts are outside.
// Notes on behaviour
// R1: Writing bit 7 of the control register to 1 enables the module, 0 disables it.
// R2: A request from the system clock generator enables the module regardless of bit 7.
// R3: Bits 6 and 3 are reserved, cannot be written and always read 0.
// R4: With bit 7 set, bit 5 at 1 keeps the clock running in Stop and 0 shuts it off.
// R5: Bit 5 has no effect while the clock generator request is high.
// R6: Bit 4 picks the output source: 0 the external pin, 1 the crystal clock.
// R7: Bit 2 picks the range: 0 low range near 32 kHz, 1 high range of 4 to 24 MHz.
// R8: Software sets the range before enabling and leaves it alone while enabled.
// R9: Bit 1 picks the amplifier mode: 0 low power, 1 high gain, in either range.
// R10: Bit 0 is set by hardware once initialization is over and reads 0 before.
// R11: When the internal enable drops the block goes off, clocks static, pins decoupled.
// R12: A rising enable with bit 4 at 1 enters startup and counts crystal edges.
// R13: The output stays gated until 4096 crystal edges were seen, then passes the crystal.
// R14: Enabled, bit 4 at 1 and count done means stable with a running output clock.
// R15: Enabled with bit 4 at 0 means external mode, pin clock forwarded without count.
// R16: The internal enable is the request OR bit 7 qualified by not-Stop or bit 5.
// R17: The startup count and the done flag clear on the way to the off state.
//
// Implementation choice: strobed register access.

`timescale 1ns/1ps

module xoc_top #(
   parameter int unsigned STARTUP_CYCLES = xoc_pkg::STARTUP_CYCLES,
   parameter int unsigned ADDR_W         = xoc_pkg::REG_ADDR_W
) (
   input  wire logic              clock,                // System clock, 100 MHz.
   input  wire logic              nrst,                 // Synchronous reset, active low.
   input  wire logic [ADDR_W-1:0] reg_addr,             // Register address.
   input  wire logic [7:0]        reg_wdata,            // Register write data.
   input  wire logic              reg_wr,               // Write strobe.
   input  wire logic              reg_rd,               // Read strobe.
   output logic      [7:0]        reg_rdata,            // Read data, cycle after strobe.
   input  wire logic              stop_mode,            // Chip is in Stop mode.
   input  wire logic              clockgen_osc_request, // Clock generator wants us on.
   input  wire logic              crystal_buf_in,       // Crystal after input buffer.
   input  wire logic              ext_clock_in_pin,     // External clock pin level.
   output logic                   crystal_clock,        // Internal crystal clock copy.
   output logic                   module_output_clock,  // Selected output clock.
   output logic                   amp_enable,           // Amplifier powered.
   output logic                   pins_coupled,         // Pins tied to the circuitry.
   output logic                   range_high,           // High frequency range.
   output logic                   high_gain_select,     // High gain amplifier mode.
   output logic                   init_done_flag        // Initialization finished.
);

   localparam logic [ADDR_W-1:0] CTRL_ADDR = ADDR_W'(xoc_pkg::OSC_CTRL_OFFSET);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations.
   logic [7:0]            oscillator_control_r;
   logic [7:0]            ctrl_view;
   logic                  module_enable_bit;
   logic                  stop_keep_on_bit;
   logic                  output_source_select;
   logic                  internal_en;
   logic                  crystal_prev_r;
   logic                  crystal_edge;
   logic                  startup_count_done;
   logic                  count_clear;
   logic                  init_r;
   logic                  out_clk_r;
   logic                  crystal_drive_pin_clk_r;
   logic                  amp_en_r;
   logic                  coupled_r;
   logic [7:0]            rdata_r;
   xoc_pkg::xoc_state_type state_r;
   xoc_pkg::xoc_state_type state_nxt;

   // Address decode used by both the write and the read path.
   function automatic logic hits_ctrl(input logic [ADDR_W-1:0] a);
      hits_ctrl = (a == CTRL_ADDR);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Control register; only writable bits change, reserved ones stay zero.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         oscillator_control_r <= xoc_pkg::CTRL_RESET;
      end else if (reg_wr && hits_ctrl(reg_addr)) begin
         oscillator_control_r <= reg_wdata & xoc_pkg::CTRL_WRITE_MASK; // [R1] [R3]
      end
   end

   // Field views of the stored control bits.
   assign module_enable_bit    = oscillator_control_r[xoc_pkg::BIT_ENABLE];
   assign stop_keep_on_bit     = oscillator_control_r[xoc_pkg::BIT_STOP_KEEP];
   assign output_source_select = oscillator_control_r[xoc_pkg::BIT_OUT_SEL];

   // Read view: stored bits, reserved bits zero, the status flag from hardware.
   always_comb begin
      ctrl_view                         = oscillator_control_r; // [R3]
      ctrl_view[xoc_pkg::BIT_INIT_DONE] = init_r; // [R10]
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data stand only in the cycle after the strobe; other addresses read 0.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         rdata_r <= 8'h00;
      end else if (reg_rd && hits_ctrl(reg_addr)) begin
         rdata_r <= ctrl_view;
      end else begin
         rdata_r <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Internal enable: the request overrides, the register bit obeys Stop.
   assign internal_en = clockgen_osc_request // [R2] [R5]
                      | (module_enable_bit
                         & (~stop_mode | stop_keep_on_bit)); // [R1] [R4] [R16]

   ////////////////////////////////////////////////////////////////////////////
   // Rising edges of the buffered crystal signal feed the startup counter.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         crystal_prev_r <= 1'b0;
      end else begin
         crystal_prev_r <= crystal_buf_in;
      end
   end

   // Only edges seen while starting up are counted.
   assign crystal_edge = crystal_buf_in & ~crystal_prev_r
                       & (state_r == xoc_pkg::XOC_ST_STARTUP); // [R12]

   // The count restarts whenever the crystal path is abandoned.
   assign count_clear = (state_nxt == xoc_pkg::XOC_ST_OFF)
                      | (state_nxt == xoc_pkg::XOC_ST_EXT); // [R17]

   xoc_startup_counter #(
      .LIMIT      (STARTUP_CYCLES)
   ) u_counter (
      .clock      (clock),
      .nrst       (nrst),
      .clear      (count_clear),
      .edge_pulse (crystal_edge),
      .done       (startup_count_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next state; a dropped enable always wins and sends the block off.
   always_comb begin
      state_nxt = state_r;
      if (!internal_en) begin
         state_nxt = xoc_pkg::XOC_ST_OFF; // [R11]
      end else begin
         unique case (state_r)
            xoc_pkg::XOC_ST_OFF: begin
               if (output_source_select) begin
                  state_nxt = xoc_pkg::XOC_ST_STARTUP; // [R12]
               end else begin
                  state_nxt = xoc_pkg::XOC_ST_EXT; // [R15]
               end
            end
            xoc_pkg::XOC_ST_STARTUP: begin
               if (!output_source_select) begin
                  state_nxt = xoc_pkg::XOC_ST_EXT; // [R6]
               end else if (startup_count_done) begin
                  state_nxt = xoc_pkg::XOC_ST_STABLE; // [R13] [R14]
               end
            end
            xoc_pkg::XOC_ST_STABLE: begin
               if (!output_source_select) begin
                  state_nxt = xoc_pkg::XOC_ST_EXT; // [R6]
               end
            end
            xoc_pkg::XOC_ST_EXT: begin
               if (output_source_select) begin
                  state_nxt = xoc_pkg::XOC_ST_STARTUP; // [R6] [R12]
               end
            end
            default: begin
               state_nxt = xoc_pkg::XOC_ST_OFF;
            end
         endcase
      end
   end

   // State register.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         state_r <= xoc_pkg::XOC_ST_OFF;
      end else begin
         state_r <= state_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Initialization flag: set by the count, cleared on the way off and while a
   // count runs, so a restart from external mode cannot report a stale done.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         init_r <= 1'b0;
      end else if ((state_nxt == xoc_pkg::XOC_ST_OFF)
                   || (state_nxt == xoc_pkg::XOC_ST_STARTUP)) begin
         init_r <= 1'b0; // [R10] [R17]
      end else if (startup_count_done) begin
         init_r <= 1'b1; // [R10]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output clock follows the source that the coming state allows.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         out_clk_r <= 1'b0;
      end else begin
         unique case (state_nxt)
            xoc_pkg::XOC_ST_STABLE:  out_clk_r <= crystal_buf_in;   // [R14]
            xoc_pkg::XOC_ST_EXT:     out_clk_r <= ext_clock_in_pin; // [R15]
            xoc_pkg::XOC_ST_STARTUP: out_clk_r <= 1'b0;             // [R13]
            default:                 out_clk_r <= 1'b0;             // [R11]
         endcase
      end
   end

   // Internal crystal clock is static while off and free otherwise.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         crystal_drive_pin_clk_r <= 1'b0;
      end else if (state_nxt == xoc_pkg::XOC_ST_OFF) begin
         crystal_drive_pin_clk_r <= 1'b0; // [R11]
      end else begin
         crystal_drive_pin_clk_r <= crystal_buf_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Analog controls: amplifier on for the crystal path, pins coupled when on.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         amp_en_r  <= 1'b0;
         coupled_r <= 1'b0;
      end else begin
         amp_en_r  <= (state_nxt == xoc_pkg::XOC_ST_STARTUP)
                    | (state_nxt == xoc_pkg::XOC_ST_STABLE);
         coupled_r <= (state_nxt != xoc_pkg::XOC_ST_OFF); // [R11]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output drive; range is taken as set before enabling.
   assign reg_rdata           = rdata_r;
   assign crystal_clock       = crystal_drive_pin_clk_r;
   assign module_output_clock = out_clk_r;
   assign amp_enable          = amp_en_r;
   assign pins_coupled        = coupled_r;
   assign range_high          = oscillator_control_r[xoc_pkg::BIT_RANGE]; // [R7]
   assign high_gain_select    = oscillator_control_r[xoc_pkg::BIT_HIGH_GAIN]; // [R9]
   assign init_done_flag      = init_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   sequence s_ctrl_write;
      reg_wr && hits_ctrl(reg_addr);
   endsequence

   sequence s_ctrl_read;
      reg_rd && hits_ctrl(reg_addr);
   endsequence

   sequence s_count_complete;
      (state_r == xoc_pkg::XOC_ST_STARTUP) && startup_count_done
      && internal_en && output_source_select;
   endsequence

   sequence s_off_then_start;
      (state_r == xoc_pkg::XOC_ST_OFF) && internal_en && output_source_select;
   endsequence

   a_enable_bit_write: assert property ( // [R1]
      @(posedge clock) disable iff (!nrst)
      s_ctrl_write |=> (module_enable_bit == $past(reg_wdata[7])))
      else $error("enable bit did not take the written value");

   a_reserved_read_zero: assert property ( // [R3]
      @(posedge clock) disable iff (!nrst)
      s_ctrl_read |=> (reg_rdata[6] == 1'b0) && (reg_rdata[3] == 1'b0))
      else $error("reserved bit read as one");

   a_request_keeps_on: assert property ( // [R2]
      @(posedge clock) disable iff (!nrst)
      clockgen_osc_request ##1 clockgen_osc_request
      |-> (state_r != xoc_pkg::XOC_ST_OFF))
      else $error("clock generator request did not enable the oscillator");

   a_stop_shutoff: assert property ( // [R4]
      @(posedge clock) disable iff (!nrst)
      (!clockgen_osc_request && stop_mode && !stop_keep_on_bit)
      |=> (state_r == xoc_pkg::XOC_ST_OFF))
      else $error("oscillator stayed on in Stop without keep-on");

   a_disable_goes_off: assert property ( // [R11]
      @(posedge clock) disable iff (!nrst)
      !internal_en |=> (state_r == xoc_pkg::XOC_ST_OFF) && !module_output_clock
                       && !crystal_clock && !pins_coupled)
      else $error("off state not static and decoupled");

   a_start_enters_count: assert property ( // [R12]
      @(posedge clock) disable iff (!nrst)
      s_off_then_start |=> (state_r == xoc_pkg::XOC_ST_STARTUP) && !init_done_flag)
      else $error("rising enable with crystal source did not start up");

   a_gated_in_startup: assert property ( // [R13]
      @(posedge clock) disable iff (!nrst)
      (state_r == xoc_pkg::XOC_ST_STARTUP) |-> !module_output_clock)
      else $error("output clock leaked during startup");

   a_done_to_stable: assert property ( // [R14]
      @(posedge clock) disable iff (!nrst)
      s_count_complete |=> (state_r == xoc_pkg::XOC_ST_STABLE) && init_done_flag
                           && (module_output_clock == $past(crystal_buf_in)))
      else $error("count done did not give a stable running clock");

   a_ext_follows_pin: assert property ( // [R15]
      @(posedge clock) disable iff (!nrst)
      (state_r == xoc_pkg::XOC_ST_EXT)
      |-> (module_output_clock == $past(ext_clock_in_pin)) && !amp_enable)
      else $error("external mode did not forward the pin clock");

   a_init_read_back: assert property ( // [R10]
      @(posedge clock) disable iff (!nrst)
      s_ctrl_read |=> (reg_rdata[0] == $past(init_r)))
      else $error("status flag read differs from hardware state");

   a_off_clears_init: assert property ( // [R17]
      @(posedge clock) disable iff (!nrst)
      (state_r == xoc_pkg::XOC_ST_OFF) |-> !init_done_flag)
      else $error("init flag survived the off state");

   a_gain_follows_bit: assert property ( // [R9]
      @(posedge clock) disable iff (!nrst)
      s_ctrl_write |=> (high_gain_select == $past(reg_wdata[1]))
                       && (range_high == $past(reg_wdata[2])))
      else $error("gain or range output differs from the written bits");

endmodule

// File: verif/xoc_crystal_drive_pin_model.sv
// Purpose: Crystal and external clock source standing at the oscillator pins.
// Assumes: Levels change just after the rising clock edge.
// Notes:   A decoupled crystal line toggles every cycle, never a stale level.

`timescale 1ns/1ps

module xoc_crystal_drive_pin_model (
   input  wire logic clock,            // System clock.
   input  wire logic amp_enable,       // Amplifier powered by the block.
   input  wire logic pins_coupled,     // Pins tied to the block.
   input  wire logic slow,             // Longer crystal period.
   output logic      crystal_buf_in,   // Crystal after the input buffer.
   output logic      ext_clock_in_pin  // Free running external clock.
);
   logic [2:0] ph_r = 3'h0;

   ////////////////////////////////////////////////////////////////////////////
   // The crystal follows the phase count while powered and coupled and toggles each cycle otherwise; the pin clock runs free.
   always @(posedge clock) begin
      ph_r <= ph_r + 3'h1;
      ext_clock_in_pin <= ph_r[0];
      if (amp_enable === 1'b1 && pins_coupled === 1'b1) begin
         crystal_buf_in <= slow ? ph_r[2] : ph_r[1];
      end else begin
         crystal_buf_in <= (crystal_buf_in === 1'b1) ? 1'b0 : 1'b1;
      end
   end
endmodule

// File: verif/tb_xoc_top.sv
// Purpose: Self-checking bench for the oscillator control block.
// Assumes: A short startup count of 8 crystal edges.
// Notes:   Checks are sampled on the falling edge, after updates have landed.

`timescale 1ns/1ps

`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin err_total++; \
   $display("Error %s expected %h seen %h", nm, ex, got); end end

module tb_xoc_top;
   localparam int N = 8;
   logic        clock = 1'b0;
   logic        nrst = 1'b0;
   logic [3:0]  reg_addr = 4'h0;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        stop_mode = 1'b0;
   logic        clockgen_osc_request = 1'b0;
   logic        slow = 1'b0;
   logic [7:0]  reg_rdata;
   logic        crystal_buf_in;
   logic        ext_clock_in_pin;
   logic        crystal_clock;
   logic        module_output_clock;
   logic        amp_enable;
   logic        pins_coupled;
   logic        range_high;
   logic        high_gain_select;
   logic        init_done_flag;
   int          err_total = 0;
   int          n_compared = 0;
   int          edges;
   logic [7:0]  rd_v;
   logic        prev;
   logic        prev_x;
   // Each row holds the written byte beside the byte that reads back.
   // An enabled row that follows an enabled row keeps its range bit, as software must.
   logic [15:0] rows [6] = '{16'h0000, 16'h4F06, 16'h7B32, 16'hFFB6, 16'hCD84, 16'h0000};

   // Free running 100 MHz clock.
   always #5 clock = ~clock;

   xoc_top #(.STARTUP_CYCLES(N), .ADDR_W(4)) u_dut (
      .clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .stop_mode(stop_mode),
      .clockgen_osc_request(clockgen_osc_request), .crystal_buf_in(crystal_buf_in),
      .ext_clock_in_pin(ext_clock_in_pin), .crystal_clock(crystal_clock),
      .module_output_clock(module_output_clock), .amp_enable(amp_enable),
      .pins_coupled(pins_coupled), .range_high(range_high),
      .high_gain_select(high_gain_select), .init_done_flag(init_done_flag));

   xoc_crystal_drive_pin_model u_crystal_drive_pin (
      .clock(clock), .amp_enable(amp_enable), .pins_coupled(pins_coupled), .slow(slow),
      .crystal_buf_in(crystal_buf_in), .ext_clock_in_pin(ext_clock_in_pin));

   ////////////////////////////////////////////////////////////////////////////
   // Prints the counts and the verdict, then stops the run.
   task complete_run;
      $display("Counts: %0d compared, %0d mismatched", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // One-cycle write strobe.
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask

   // One-cycle read strobe; data is taken in the following cycle only.
   task rd(input logic [3:0] a);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(negedge clock);
      rd_v = reg_rdata;
   endtask

   // Waits for the done flag, counting crystal edges while the output is held.
   task wait_init;
      edges = 0;
      for (int i = 0; i < 400 && init_done_flag !== 1'b1; i++) begin
         @(negedge clock);
         if (amp_enable === 1'b1 && init_done_flag !== 1'b1) begin
            `CHK("gated output", 1'b0, module_output_clock)
            if (prev === 1'b0 && crystal_buf_in === 1'b1) edges++;
         end
         prev = crystal_buf_in;
      end
      if (init_done_flag !== 1'b1) begin
         err_total++;
         complete_run();
      end
      `CHK("startup edges", 1'b1, edges >= N - 1 && edges <= N + 1)
   endtask

   // The output must follow the chosen source one cycle late.
   task chk_copy(input logic use_ext);
      @(negedge clock);
      prev = use_ext ? ext_clock_in_pin : crystal_buf_in;
      prev_x = crystal_buf_in;
      repeat (6) begin
         @(negedge clock);
         `CHK("output copy", prev, module_output_clock)
         `CHK("crystal copy", prev_x, crystal_clock)
         prev = use_ext ? ext_clock_in_pin : crystal_buf_in;
         prev_x = crystal_buf_in;
      end
   endtask

   // Everything static and decoupled in the off state.
   task chk_off;
      repeat (3) @(negedge clock);
      `CHK("off outputs", 5'h00, {pins_coupled, amp_enable, init_done_flag,
                                  module_output_clock, crystal_clock})
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence: reset, table of register rows, then hand-written cases.
   initial begin
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      chk_off();
      for (int i = 0; i < 6; i++) begin
         wr(4'h0, rows[i][15:8]);
         rd(4'h0);
         `CHK("control read", rows[i][7:0], rd_v)
         `CHK("range", rows[i][2], range_high)
         `CHK("gain", rows[i][1], high_gain_select)
      end
      wr(4'h3, 8'hB6);
      rd(4'h3);
      `CHK("unmapped read", 8'h00, rd_v)
      @(negedge clock);
      `CHK("read idle", 8'h00, reg_rdata)
      rd(4'h0);
      `CHK("unmapped write", 8'h00, rd_v)
      $display("Test register table done");
      wr(4'h0, 8'h96);
      wait_init();
      rd(4'h0);
      `CHK("init flag", 8'h97, rd_v)
      chk_copy(1'b0);
      $display("Test startup done");
      @(posedge clock);
      stop_mode <= 1'b1;
      chk_off();
      rd(4'h0);
      `CHK("init cleared", 8'h96, rd_v)
      @(posedge clock);
      clockgen_osc_request <= 1'b1;
      slow <= 1'b1;
      wait_init();
      chk_copy(1'b0);
      wr(4'h0, 8'hB6);
      @(posedge clock);
      clockgen_osc_request <= 1'b0;
      repeat (3) @(negedge clock);
      `CHK("stop keep on", 2'h3, {pins_coupled, init_done_flag})
      $display("Test stop mode done");
      wr(4'h0, 8'hA6);
      repeat (3) @(negedge clock);
      `CHK("ext mode", 2'h1, {amp_enable, pins_coupled})
      chk_copy(1'b1);
      wr(4'h0, 8'h00);
      chk_off();
      // Stop is still high, so the keep-on bit is needed to stay enabled.
      wr(4'h0, 8'hA0);
      repeat (3) @(negedge clock);
      chk_copy(1'b1);
      `CHK("ext no count", 1'b0, init_done_flag)
      // Switching back to the crystal while on restarts the full count.
      wr(4'h0, 8'hB0);
      wait_init();
      chk_copy(1'b0);
      $display("Test external clock done");
      @(posedge clock);
      nrst <= 1'b0;
      @(posedge clock);
      nrst <= 1'b1;
      chk_off();
      rd(4'h0);
      `CHK("reset value", 8'h00, rd_v)
      $display("Test second reset done");
      complete_run();
   end
endmodule
